// file: hw/ctx_sched.sv
// Purpose: context scheduler with execution, max-time and idle timers
// Assumes: bus writes come from code of the running context
// Notes:   new grant is registered in the same cycle as the state change
//
// How it works
// - master context always outranks others, whatever priority it holds.
// - access-controlled writes take effect only from the master context.
// - after reset only the master runs; others halted, options off.
// - each context has priority 0..7 in its control word, higher wins.
// - control word selects standard, fast-vectored or fast single-thread.
// - control word holds run state: runnable, sleeping or halted.
// - grant always goes to the highest runnable context, deterministic.
// - sleep request moves the running context to sleeping.
// - a sleeping context wakes to runnable only on its own interrupt.
// - a woken fast single-thread context resumes at its saved pc.
// - any write to a context's actuation word fires its soft interrupt.
// - soft and overtime interrupts have status, wake pins none; reading it acknowledges.
// - one master-only enable word enables timers per context.
// - the same word selects standard or time-slice timer mode.
// - each context has a counter; write access depends on timer mode.
// - master-only clear word resets execution-time counters.
// - read-only idle counter counts only while no context runs.
// - per-context max-time word, written by the master only.
// - standard mode overtime raises a fault towards the master.
// - standard mode overtime records the offending context id.
// - time-slice overtime raises a local exception in that context.
// - counter keeps running while the bus is yielded to another master.
// - timers and optional features start disabled and inert.
// - faulted-context id sits in bits 7:0, upper bits read zero.
// - reset loads master control 0x1F02, others 0x1800.
//
// The register addresses and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ns
`include "ctx_sched_defines.svh"

module ctx_sched #(
  parameter int NUM_CTX = `CTX_NUM
) (
  input  wire logic                    clk,
  input  wire logic                    rst_b,
  input  wire ctx_sched_pkg::axiReq_t  axiReq,
  output      ctx_sched_pkg::axiRsp_t  axiRsp,
  input  wire logic [`CTX_NUM-1:0]     irqWake,
  input  wire logic                    sleepReq,
  output      logic [`CTX_IDW-1:0]     runCtx,
  output      logic                    runValid,
  output      logic [1:0]              runType,
  output      logic                    resumeAtPc,
  output      logic                    overtimeFault,
  output      logic                    overtimeLocal
);

  if (NUM_CTX != `CTX_NUM) begin : gChk
    $error("NUM_CTX must match the register layout");
  end

  ctx_sched_pkg::state_t q;
  ctx_sched_pkg::state_t n;
  logic                  rstMeta_b;
  logic                  rstSync_b;

  // reset release is synchronised; assertion stays asynchronous
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rstMeta_b <= 1'b0;
      rstSync_b <= 1'b0;
    end else begin
      rstMeta_b <= 1'b1;
      rstSync_b <= rstMeta_b;
    end
  end

  function automatic logic [31:0] strbMerge(input logic [31:0] old,
                                            input logic [31:0] val,
                                            input logic [3:0]  strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = val[b*8 +: 8];
      end
    end
    return res;
  endfunction : strbMerge

  function automatic ctx_sched_pkg::state_t resetState();
    ctx_sched_pkg::state_t s;
    s = '0;
    s.ctrl[0] = `CTRL_RST_MASTER;
    for (int i = 1; i < `CTX_NUM; i++) begin
      s.ctrl[i] = `CTRL_RST_OTHER;
    end
    s.runValid = 1'b1;
    s.runCtx   = `MASTER_ID;
    return s;
  endfunction : resetState

  logic                 doWr;
  logic                 doRd;
  logic                 isMaster;
  logic [2:0]           wGrp;
  logic [2:0]           wIdx;
  logic [2:0]           rGrp;
  logic [2:0]           rIdx;
  logic [31:0]          rdVal;
  logic [1:0]           rdResp;
  logic                 statRead;
  logic [`CTX_NUM-1:0]  swiFire;
  logic [`CTX_NUM-1:0]  tmrClr;
  logic [3:0]           bestPrio;
  logic [3:0]           prio;
  logic                 running;
  logic [`CTX_IDW-1:0]  bestCtx;
  logic                 bestValid;
  // merged word kept apart: a select on a call result is not legal
  logic [31:0]          ctrlMrg;

  always_comb begin
    n = q;
    n.faultPulse = 1'b0;
    n.localPulse = 1'b0;
    swiFire  = '0;
    tmrClr   = '0;
    rdVal    = '0;
    rdResp   = `RESP_OKAY;
    statRead = 1'b0;
    bestPrio = '0;
    prio     = '0;
    running  = 1'b0;
    bestCtx  = `MASTER_ID;
    bestValid = 1'b0;
    ctrlMrg  = '0;
    isMaster = q.runValid && (q.runCtx == `MASTER_ID);

    // wake pins pass two flops before use
    n.irqMeta = irqWake;
    n.irqSync = q.irqMeta;

    // write channel: address and data taken independently
    if (!q.awHeld && axiReq.awvalid) begin
      n.awHeld = 1'b1;
      n.awAddr = axiReq.awaddr;
    end
    if (!q.wHeld && axiReq.wvalid) begin
      n.wHeld = 1'b1;
      n.wData = axiReq.wdata;
      n.wStrb = axiReq.wstrb;
    end
    if (q.bValid && axiReq.bready) begin
      n.bValid = 1'b0;
    end
    doWr = q.awHeld && q.wHeld && !q.bValid;
    wGrp = q.awAddr[7:5];
    wIdx = q.awAddr[4:2];
    if (doWr) begin
      n.awHeld = 1'b0;
      n.wHeld  = 1'b0;
      n.bValid = 1'b1;
      n.bResp  = `RESP_OKAY;
      unique case (wGrp)
        `GRP_CTRL: begin
          if (wIdx >= 3'(`CTX_NUM)) begin
            n.bResp = `RESP_DECERR;
          end
        end
        `GRP_TMREN: begin
          if (wIdx != 3'h0) begin
            n.bResp = `RESP_DECERR;
          end else if (isMaster) begin
            n.tmrEn     = q.wData[`CTX_NUM-1:0];
            n.sliceMode = q.wData[`TMREN_MODE_BIT];
          end
        end
        `GRP_TIMER, `GRP_MAXT: begin
          if (wIdx >= 3'(`CTX_NUM)) begin
            n.bResp = `RESP_DECERR;
          end
        end
        `GRP_MISC: begin
          if (wIdx > `IDX_STAT) begin
            n.bResp = `RESP_DECERR;
          end else if (wIdx == `IDX_TCLR && isMaster) begin
            tmrClr = q.wData[`CTX_NUM-1:0];
          end
        end
        `GRP_SWACT: begin
          if (wIdx >= 3'(`CTX_NUM)) begin
            n.bResp = `RESP_DECERR;
          end else begin
            swiFire[wIdx] = 1'b1;
          end
        end
        default: n.bResp = `RESP_DECERR;
      endcase
    end

    // read channel; status read is the acknowledge
    if (q.rValid && axiReq.rready) begin
      n.rValid = 1'b0;
    end
    doRd = !q.rValid && axiReq.arvalid;
    rGrp = axiReq.araddr[7:5];
    rIdx = axiReq.araddr[4:2];
    if (rIdx < 3'(`CTX_NUM)) begin
      unique case (rGrp)
        `GRP_CTRL:  rdVal = {16'h0000, q.ctrl[rIdx]};
        `GRP_TIMER: rdVal = q.timer[rIdx];
        `GRP_MAXT:  rdVal = q.maxT[rIdx];
        `GRP_SWACT: rdVal = '0;
        `GRP_TMREN: begin
          rdVal = '0;
          if (rIdx == 3'h0) begin
            rdVal[`CTX_NUM-1:0]     = q.tmrEn;
            rdVal[`TMREN_MODE_BIT]  = q.sliceMode;
          end else begin
            rdResp = `RESP_DECERR;
          end
        end
        `GRP_MISC: begin
          unique case (rIdx)
            `IDX_TCLR:  rdVal = '0;
            `IDX_IDLE:  rdVal = q.idle;
            `IDX_FAULT: rdVal = {24'h00_0000, q.faultId};
            `IDX_STAT: begin
              rdVal[`STAT_SWI_LO +: `CTX_NUM] = q.swiPend;
              rdVal[`STAT_FLT_BIT]            = q.faultPend;
              rdVal[`STAT_LOC_LO +: `CTX_NUM] = q.localPend;
              statRead = doRd;
            end
            default: rdResp = `RESP_DECERR;
          endcase
        end
        default: rdResp = `RESP_DECERR;
      endcase
    end else begin
      rdResp = `RESP_DECERR;
    end
    if (doRd) begin
      n.rValid = 1'b1;
      n.rData  = (rdResp == `RESP_OKAY) ? rdVal : 32'h0000_0000;
      n.rResp  = rdResp;
    end
    // acknowledge first, so that a new event in this cycle survives
    if (statRead) begin
      n.swiPend   = '0;
      n.faultPend = 1'b0;
      n.localPend = '0;
    end

    for (int i = 0; i < `CTX_NUM; i++) begin
      running = q.runValid && (q.runCtx == `CTX_IDW'(i));
      if (swiFire[i]) begin
        n.swiPend[i] = 1'b1;
      end
      // hardware state moves
      if (sleepReq && running &&
          q.ctrl[i][`ST_HI:`ST_LO] == `ST_RUN) begin
        n.ctrl[i][`ST_HI:`ST_LO] = `ST_SLEEP;
      end
      if ((q.irqSync[i] || swiFire[i]) &&
          q.ctrl[i][`ST_HI:`ST_LO] == `ST_SLEEP) begin
        n.ctrl[i][`ST_HI:`ST_LO] = `ST_RUN;
      end
      // master configuration wins over a same-cycle hardware move
      if (doWr && wGrp == `GRP_CTRL && wIdx == `CTX_IDW'(i) && isMaster) begin
        // strobes first, then the mask keeps reserved bits
        ctrlMrg   = strbMerge({16'h0000, q.ctrl[i]}, q.wData, q.wStrb);
        n.ctrl[i] = (q.ctrl[i] & ~`CTRL_WR_MASK) |
                    (ctrlMrg[15:0] & `CTRL_WR_MASK);
      end
      if (doWr && wGrp == `GRP_MAXT && wIdx == `CTX_IDW'(i) && isMaster) begin
        n.maxT[i] = strbMerge(q.maxT[i], q.wData, q.wStrb);
      end
      // counting goes on regardless of who owns the external bus
      if (q.tmrEn[i] && running) begin
        n.timer[i] = q.timer[i] + `TMR_W'(1);
      end
      // owner may write its counter only in time-slice mode
      if (doWr && wGrp == `GRP_TIMER && wIdx == `CTX_IDW'(i) &&
          q.sliceMode && running) begin
        n.timer[i] = strbMerge(q.timer[i], q.wData, q.wStrb);
      end
      if (tmrClr[i]) begin
        n.timer[i]    = '0;
        n.overSeen[i] = 1'b0;
      end
      // one exception per overrun until the counter is cleared
      if (q.tmrEn[i] && !q.overSeen[i] && q.timer[i] > q.maxT[i]) begin
        n.overSeen[i] = 1'b1;
        if (q.sliceMode) begin
          n.localPulse   = 1'b1;
          n.localPend[i] = 1'b1;
        end else begin
          n.faultPulse = 1'b1;
          n.faultPend  = 1'b1;
          n.faultId    = 8'(i);
        end
      end
    end

    // idle time: nothing granted this cycle
    if (!q.runValid) begin
      n.idle = q.idle + `TMR_W'(1);
    end

    // grant from the updated states; ties go to the lower index
    for (int i = 0; i < `CTX_NUM; i++) begin
      prio = (i == 0) ? `MASTER_PRIO
                      : {1'b0, n.ctrl[i][`PRIO_HI:`PRIO_LO]};
      if (n.ctrl[i][`ST_HI:`ST_LO] == `ST_RUN &&
          (!bestValid || prio > bestPrio)) begin
        bestValid = 1'b1;
        bestPrio  = prio;
        bestCtx   = `CTX_IDW'(i);
      end
    end
    n.runValid = bestValid;
    n.runCtx   = bestCtx;
    n.runType  = bestValid ? n.ctrl[bestCtx][`TYPE_HI:`TYPE_LO] : `TYPE_STD;
  end

  always_ff @(posedge clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      q <= resetState();
    end else begin
      q <= n;
    end
  end

  assign axiRsp.awready = !q.awHeld;
  assign axiRsp.wready  = !q.wHeld;
  assign axiRsp.bvalid  = q.bValid;
  assign axiRsp.bresp   = q.bResp;
  assign axiRsp.arready = !q.rValid;
  assign axiRsp.rvalid  = q.rValid;
  assign axiRsp.rdata   = q.rData;
  assign axiRsp.rresp   = q.rResp;
  assign runCtx         = q.runCtx;
  assign runValid       = q.runValid;
  assign runType        = q.runType;
  // no vector fetch: the core carries on from its saved pc
  assign resumeAtPc     = q.runValid && q.runType == `TYPE_FST;
  assign overtimeFault  = q.faultPulse;
  assign overtimeLocal  = q.localPulse;

endmodule : ctx_sched

// file: hw/ctx_sched_defines.svh
// Purpose: constants of the context scheduler and its register map
// Assumes: 32-bit AXI4-Lite data, byte addresses
// Notes:   fields of the per-context control word
`ifndef CTX_SCHED_DEFINES_SVH
`define CTX_SCHED_DEFINES_SVH
`define CTX_NUM         5
`define CTX_IDW         3
`define TMR_W           32
`define ADDR_W          8
// address groups: addr[7:5] picks the group, addr[4:2] the entry
`define GRP_CTRL        3'h0
`define GRP_TMREN       3'h1
`define GRP_TIMER       3'h2
`define GRP_MAXT        3'h3
`define GRP_MISC        3'h4
`define GRP_SWACT       3'h5
`define IDX_TCLR        3'h0
`define IDX_IDLE        3'h1
`define IDX_FAULT       3'h2
`define IDX_STAT        3'h3
// control word
`define CTRL_RST_MASTER 16'h1F02
`define CTRL_RST_OTHER  16'h1800
`define CTRL_WR_MASK    16'h6703
`define ST_LO           0
`define ST_HI           1
`define PRIO_LO         8
`define PRIO_HI         10
`define TYPE_LO         13
`define TYPE_HI         14
`define ST_HALT         2'h0
`define ST_SLEEP        2'h1
`define ST_RUN          2'h2
`define TYPE_STD        2'h0
`define TYPE_FV         2'h1
`define TYPE_FST        2'h2
// timer enable and status words
`define TMREN_MODE_BIT  8
`define STAT_SWI_LO     0
`define STAT_FLT_BIT    8
`define STAT_LOC_LO     16
`define MASTER_ID       3'h0
`define MASTER_PRIO     4'h8
`define RESP_OKAY       2'h0
`define RESP_DECERR     2'h3
`endif

// file: hw/ctx_sched_pkg.sv
// Purpose: types of the context scheduler
// Assumes: constants from ctx_sched_defines.svh
// Notes:   state of the block, apart from the reset synchroniser flops, is one packed struct
`include "ctx_sched_defines.svh"
package ctx_sched_pkg;
  typedef struct packed {
    logic                awvalid;
    logic [`ADDR_W-1:0]  awaddr;
    logic                wvalid;
    logic [31:0]         wdata;
    logic [3:0]          wstrb;
    logic                bready;
    logic                arvalid;
    logic [`ADDR_W-1:0]  araddr;
    logic                rready;
  } axiReq_t;

  typedef struct packed {
    logic                awready;
    logic                wready;
    logic                bvalid;
    logic [1:0]          bresp;
    logic                arready;
    logic                rvalid;
    logic [31:0]         rdata;
    logic [1:0]          rresp;
  } axiRsp_t;

  typedef struct packed {
    logic                          awHeld;
    logic [`ADDR_W-1:0]            awAddr;
    logic                          wHeld;
    logic [31:0]                   wData;
    logic [3:0]                    wStrb;
    logic                          bValid;
    logic [1:0]                    bResp;
    logic                          rValid;
    logic [31:0]                   rData;
    logic [1:0]                    rResp;
    logic [`CTX_NUM-1:0]           irqMeta;
    logic [`CTX_NUM-1:0]           irqSync;
    logic [`CTX_NUM-1:0][15:0]     ctrl;
    logic [`CTX_NUM-1:0]           tmrEn;
    logic                          sliceMode;
    logic [`CTX_NUM-1:0][`TMR_W-1:0] timer;
    logic [`CTX_NUM-1:0][`TMR_W-1:0] maxT;
    logic [`CTX_NUM-1:0]           overSeen;
    logic [`TMR_W-1:0]             idle;
    logic [7:0]                    faultId;
    logic [`CTX_NUM-1:0]           swiPend;
    logic                          faultPend;
    logic [`CTX_NUM-1:0]           localPend;
    logic [`CTX_IDW-1:0]           runCtx;
    logic                          runValid;
    logic [1:0]                    runType;
    logic                          faultPulse;
    logic                          localPulse;
  } state_t;
endpackage : ctx_sched_pkg

// file: tb/ctx_sched_monitor.sv
// Purpose: concurrent checks on the context scheduler ports
// Assumes: one clock domain, rst_b active low
// Notes:   sees only the top-level ports, attached by bind
`timescale 1ns/1ns
`include "ctx_sched_defines.svh"
module ctx_sched_monitor #(
  parameter int NUM_CTX = 5
) (
  input wire logic                   clk,
  input wire logic                   rst_b,
  input wire ctx_sched_pkg::axiReq_t axiReq,
  input wire ctx_sched_pkg::axiRsp_t axiRsp,
  input wire logic [`CTX_NUM-1:0]    irqWake,
  input wire logic                   sleepReq,
  input wire logic [`CTX_IDW-1:0]    runCtx,
  input wire logic                   runValid,
  input wire logic [1:0]             runType,
  input wire logic                   resumeAtPc,
  input wire logic                   overtimeFault,
  input wire logic                   overtimeLocal
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  reset_master_a: assert property (
    $rose(rst_b) |-> (runValid && runCtx == `MASTER_ID && runType == 2'h0)[*3])
    else $error("master not granted after reset");
  resume_pc_a: assert property (
    resumeAtPc == (runValid && runType == `TYPE_FST))
    else $error("resume flag wrong for granted type");
  wake_master_a: assert property (
    $rose(irqWake[0]) |-> ##[1:4] (runValid && runCtx == `MASTER_ID))
    else $error("master not woken by its interrupt");
  // wake sync is two flops deep, so look back two samples for quiet pins
  sleep_leave_a: assert property (
    sleepReq && runValid && irqWake == '0 && $past(irqWake) == '0 &&
    $past(irqWake, 2) == '0 |=> !(runValid && runCtx == $past(runCtx)))
    else $error("sleeping context kept the grant");
  stable_grant_a: assert property (
    !sleepReq && irqWake == '0 && $past(irqWake) == '0 &&
    $past(irqWake, 2) == '0 && (axiRsp.awready || axiRsp.wready) &&
    !overtimeFault |=> $stable({runValid, runCtx}))
    else $error("grant moved without a cause");
  fault_pulse_a: assert property (
    overtimeFault |=> !overtimeFault)
    else $error("overtime fault longer than one cycle");
  local_pulse_a: assert property (
    overtimeLocal |=> !overtimeLocal)
    else $error("local overtime longer than one cycle");
  one_mode_a: assert property (
    !(overtimeFault && overtimeLocal))
    else $error("both overtime kinds at once");

  cover property (sleepReq && runValid);
  cover property (overtimeFault);
  cover property (overtimeLocal);
  cover property (resumeAtPc);
endmodule : ctx_sched_monitor

// file: tb/ctx_sched_tb.sv
// Purpose: self-checking bench for the context scheduler
// Assumes: reads are checked by a watcher from a queue of expectations
// Notes:   idle count expectation depends on the fixed waits below
`timescale 1ns/1ns
`include "ctx_sched_defines.svh"
module ctx_sched_tb;
  logic                   clk;
  logic                   rst_b;
  ctx_sched_pkg::axiReq_t axiReq;
  ctx_sched_pkg::axiRsp_t axiRsp;
  logic [4:0]             irqWake;
  logic                   sleepReq;
  logic [2:0]             runCtx;
  logic                   runValid;
  logic [1:0]             runType;
  logic                   resumeAtPc;
  logic                   overtimeFault;
  logic                   overtimeLocal;
  logic [33:0]            expQ[$];
  logic [33:0]            expHead;
  logic [1:0]             bexpQ[$];
  logic [31:0]            maxT;
  int                     n_errors;
  int                     check_count;

  ctx_sched #(.NUM_CTX(5)) dut (
    .clk(clk), .rst_b(rst_b), .axiReq(axiReq), .axiRsp(axiRsp),
    .irqWake(irqWake), .sleepReq(sleepReq), .runCtx(runCtx),
    .runValid(runValid), .runType(runType), .resumeAtPc(resumeAtPc),
    .overtimeFault(overtimeFault), .overtimeLocal(overtimeLocal)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict

  // bready and rready stay high for the whole run
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r = 2'h0);
    int   n;
    logic aw;
    logic w;
    n = 0;
    aw = 1'b1;
    w = 1'b1;
    bexpQ.push_back(r);
    axiReq.awaddr <= a;
    axiReq.wdata <= d;
    axiReq.wstrb <= 4'hF;
    axiReq.awvalid <= 1'b1;
    axiReq.wvalid <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (aw && axiRsp.awready) begin
        aw = 1'b0;
        axiReq.awvalid <= 1'b0;
      end
      if (w && axiRsp.wready) begin
        w = 1'b0;
        axiReq.wvalid <= 1'b0;
      end
    end while (!axiRsp.bvalid && n < 50);
    if (n >= 50) begin
      n_errors++;
      give_verdict();
    end
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    int n;
    n = 0;
    expQ.push_back({r, d});
    axiReq.araddr <= a;
    axiReq.arvalid <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (axiReq.arvalid && axiRsp.arready)
        axiReq.arvalid <= 1'b0;
    end while (!axiRsp.rvalid && n < 50);
    if (n >= 50) begin
      n_errors++;
      give_verdict();
    end
  endtask : rd

  task automatic slp;
    sleepReq <= 1'b1;
    @(posedge clk);
    sleepReq <= 1'b0;
  endtask : slp

  task automatic chkGrant(input logic v, input logic [2:0] id);
    #1;
    chk({31'h0, runValid}, {31'h0, v});
    if (v)
      chk({29'h0, runCtx}, {29'h0, id});
    @(posedge clk);
  endtask : chkGrant

  task automatic wakeMaster;
    irqWake <= 5'h01;
    repeat (3) @(posedge clk);
    irqWake <= 5'h00;
  endtask : wakeMaster

  task automatic waitPulse(input logic slice);
    logic hit;
    hit = 1'b0;
    for (int n = 0; n < 100 && !hit; n++) begin
      @(posedge clk);
      hit = slice ? overtimeLocal : overtimeFault;
    end
    chk({31'h0, hit}, 32'h0000_0001);
    if (!hit)
      give_verdict();
  endtask : waitPulse

  // watcher: every read answer taken is compared with the oldest note
  always @(posedge clk) begin
    if (rst_b && axiRsp.rvalid && axiReq.rready) begin
      expHead = expQ.pop_front();
      chk(axiRsp.rdata, expHead[31:0]);
      chk({30'h0, axiRsp.rresp}, {30'h0, expHead[33:32]});
    end
    if (rst_b && axiRsp.bvalid && axiReq.bready) begin
      chk({30'h0, axiRsp.bresp}, {30'h0, bexpQ.pop_front()});
    end
  end

  initial begin
    repeat (100000) @(posedge clk);
    n_errors++;
    give_verdict();
  end

  initial begin
    rst_b = 1'b0;
    axiReq = '0;
    axiReq.bready = 1'b1;
    axiReq.rready = 1'b1;
    irqWake = 5'h00;
    sleepReq = 1'b0;
    n_errors = 0;
    check_count = 0;
    void'($urandom(98));
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    rd(8'h00, 32'h0000_1F02, 2'h0);
    for (int i = 1; i < 5; i++)
      rd(8'(i * 4), 32'h0000_1800, 2'h0);
    rd(8'h20, 32'h0000_0000, 2'h0);
    rd(8'h88, 32'h0000_0000, 2'h0);
    rd(8'hFC, 32'h0000_0000, 2'h3);
    wr(8'hE0, $urandom, 2'h3);
    $display("reset test done");
    wr(8'h04, 32'h0000_4601);
    wr(8'h0C, 32'h0000_0102);
    wr(8'h00, 32'h0000_0002);
    rd(8'h04, 32'h0000_5E01, 2'h0);
    rd(8'h00, 32'h0000_1802, 2'h0);
    chkGrant(1'b1, 3'h0);
    slp();
    chkGrant(1'b1, 3'h3);
    chk({31'h0, resumeAtPc}, 32'h0000_0000);
    // non-master writers: random data must leave no trace
    wr(8'h04, $urandom);
    wr(8'h20, $urandom);
    wr(8'h6C, $urandom);
    rd(8'h04, 32'h0000_5E01, 2'h0);
    rd(8'h20, 32'h0000_0000, 2'h0);
    rd(8'h6C, 32'h0000_0000, 2'h0);
    wr(8'hA4, $urandom);
    chkGrant(1'b1, 3'h1);
    chk({31'h0, resumeAtPc}, 32'h0000_0001);
    rd(8'h8C, 32'h0000_0002, 2'h0);
    rd(8'h8C, 32'h0000_0000, 2'h0);
    slp();
    chkGrant(1'b1, 3'h3);
    wakeMaster();
    chkGrant(1'b1, 3'h0);
    $display("scheduling test done");
    maxT = 32'h0000_0003 + $urandom % 6;
    wr(8'h6C, maxT);
    wr(8'h20, 32'h0000_0008);
    wr(8'h80, 32'h0000_001F);
    rd(8'h6C, maxT, 2'h0);
    rd(8'h20, 32'h0000_0008, 2'h0);
    slp();
    chkGrant(1'b1, 3'h3);
    waitPulse(1'b0);
    rd(8'h88, 32'h0000_0003, 2'h0);
    wakeMaster();
    chkGrant(1'b1, 3'h0);
    $display("standard timer test done");
    wr(8'h20, 32'h0000_0108);
    wr(8'h80, 32'h0000_0008);
    wr(8'h4C, 32'h0000_0055);
    rd(8'h4C, 32'h0000_0000, 2'h0);
    slp();
    chkGrant(1'b1, 3'h3);
    waitPulse(1'b1);
    wakeMaster();
    chkGrant(1'b1, 3'h0);
    $display("time slice test done");
    wr(8'h0C, 32'h0000_0101);
    slp();
    chkGrant(1'b0, 3'h0);
    repeat (20) @(posedge clk);
    wakeMaster();
    chkGrant(1'b1, 3'h0);
    rd(8'h84, 32'h0000_0018, 2'h0);
    $display("idle test done");
    repeat (2) @(posedge clk);
    give_verdict();
  end
endmodule : ctx_sched_tb

bind ctx_sched ctx_sched_monitor #(.NUM_CTX(NUM_CTX)) mon (
  .clk(clk), .rst_b(rst_b), .axiReq(axiReq), .axiRsp(axiRsp),
  .irqWake(irqWake), .sleepReq(sleepReq), .runCtx(runCtx),
  .runValid(runValid), .runType(runType), .resumeAtPc(resumeAtPc),
  .overtimeFault(overtimeFault), .overtimeLocal(overtimeLocal)
);
